// ===== rtl/tsm_pkg.sv
// Constants and types shared by both ends of the touch scan link.
// Assumes a 200 MHz core clock on both ends.
package tsm_pkg;
  localparam int CLK_MHZ = 200;
  localparam int NREG = 64;
  localparam logic [6:0] DEV_ADDR = 7'h2b;
  // Register offsets inside the device, one byte each.
  localparam logic [5:0] A_STAT = 6'h00;
  localparam logic [5:0] A_TOUCH = 6'h01;
  localparam logic [5:0] A_MODE = 6'h02;
  localparam logic [5:0] A_PER_ACT = 6'h03;
  localparam logic [5:0] A_PER_DOZE = 6'h04;
  localparam logic [5:0] A_PASSIVE = 6'h05;
  localparam logic [5:0] A_AUTOLIGHT = 6'h06;
  localparam logic [5:0] A_FADE_ON = 6'h07;
  localparam logic [5:0] A_DIRECT = 6'h08;
  localparam logic [5:0] A_SPECIAL = 6'h09;
  localparam logic [5:0] A_FADE_CFG = 6'h0a;
  localparam logic [5:0] A_FADE_MIN = 6'h0b;
  localparam logic [5:0] A_FADE_MAX = 6'h0c;
  localparam logic [5:0] A_AOI_MAP = 6'h0d;
  localparam logic [5:0] A_THR = 6'h0e;
  localparam logic [5:0] A_HYS = 6'h0f;
  localparam logic [5:0] A_BUZZ_EN = 6'h10;
  localparam logic [5:0] A_SENSE_EN = 6'h11;
  localparam logic [5:0] A_AOI_IDLE = 6'h12;
  localparam logic [5:0] A_WIDTH = 6'h20;
  localparam logic [5:0] A_AOI_LVL = 6'h28;
  // Reset values of the registers that are not zero.
  localparam logic [7:0] R_PER_ACT = 8'h02;
  localparam logic [7:0] R_PER_DOZE = 8'h0d;
  localparam logic [7:0] R_PASSIVE = 8'h20;
  localparam logic [7:0] R_AUTOLIGHT = 8'h01;
  localparam logic [7:0] R_FADE_CFG = 8'h01;
  localparam logic [7:0] R_FADE_MAX = 8'hff;
  localparam logic [7:0] R_THR = 8'h80;
  localparam logic [7:0] R_HYS = 8'h08;
  localparam logic [7:0] R_SENSE_EN = 8'hff;
  // Field positions.
  localparam int FADE_LOG_BIT = 7;
  localparam int PIN_LEVEL_CODED_OUTPUT_A = 7;
  localparam int PIN_LEVEL_CODED_OUTPUT_B = 6;
  localparam int PIN_BUZZ = 5;
  // Values of the mode-control register.
  localparam logic [7:0] MC_AUTO = 8'h00;
  localparam logic [7:0] MC_ACTIVE = 8'h01;
  localparam logic [7:0] MC_DOZE = 8'h02;
  localparam logic [7:0] MC_SLEEP = 8'h03;
  // Timing; the scan period register counts units of PERIOD_UNIT_MS.
  localparam int PERIOD_UNIT_MS = 15;
  localparam int UNIT_CYC = PERIOD_UNIT_MS * 1000 * CLK_MHZ;
  localparam int BUZZ_MS = 30;
  localparam int BUZZ_CYC = BUZZ_MS * 1000 * CLK_MHZ;
  localparam int TONE_HZ = 4000;
  localparam int TONE_HALF_CYC = CLK_MHZ * 1000000 / (2 * TONE_HZ);
  localparam int FADE_TICK_US = 1000;
  localparam int FADE_TICK_CYC = FADE_TICK_US * CLK_MHZ;
  localparam int LINK_KHZ = 400;
  localparam int QUART_CYC = CLK_MHZ * 1000 / (4 * LINK_KHZ);
  // Host command port registers.
  localparam logic [2:0] H_CMD = 3'h0;
  localparam logic [2:0] H_REG = 3'h1;
  localparam logic [2:0] H_WDATA = 3'h2;
  localparam logic [2:0] H_RDATA = 3'h3;
  localparam logic [2:0] H_STAT = 3'h4;
  typedef enum logic [1:0] {MODE_ACTIVE, MODE_DOZE} tsm_mode_t;
  typedef enum logic [2:0] {SC_BOOT = 3'b000, SC_SENSE = 3'b001,
    SC_PROC = 3'b011, SC_WAIT = 3'b010, SC_SLEEP = 3'b110} tsm_scan_t;
  typedef enum logic [2:0] {SL_IDLE = 3'b000, SL_ADDR = 3'b001,
    SL_ACKA = 3'b011, SL_WR = 3'b010, SL_ACKW = 3'b110, SL_RD = 3'b111,
    SL_ACKR = 3'b101} tsm_slave_t;
  typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_START = 2'b01,
    HS_BIT = 2'b11, HS_STOP = 2'b10} tsm_hst_t;
endpackage

// ===== rtl/tsm_link_if.sv
// Two-wire link with interrupt between host and touch device.
// Assumes pull-ups: a wire is high unless an enabled driver pulls it low.
`timescale 1ns/1ps
interface tsm_link_if;
  logic host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n;
  logic dev_sda_o, dev_sda_oe_n, dev_irq_o, dev_irq_oe_n;
  logic scl, sda, irq_n;
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);
  assign irq_n = dev_irq_oe_n | dev_irq_o;
  modport dev (input scl, sda, output dev_sda_o, dev_sda_oe_n, dev_irq_o,
    dev_irq_oe_n);
  modport host (input scl, sda, irq_n, output host_scl_o, host_scl_oe_n,
    host_sda_o, host_sda_oe_n);
endinterface

// ===== rtl/tsm_device.sv
// Touch device end: scan sequencer, modes, LED and special outputs, slave.
// Assumes a charge-count front end and a boot memory on core_clk.
`timescale 1ns/1ps
module tsm_device import tsm_pkg::*; #(
  parameter int UNIT_CYCLES = UNIT_CYC,
  parameter int BUZZ_CYCLES = BUZZ_CYC,
  parameter int TONE_CYCLES = TONE_HALF_CYC,
  parameter int FADE_CYCLES = FADE_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  tsm_link_if.dev link,
  output logic conv_req,
  output logic [2:0] conv_idx,
  input wire logic conv_done,
  input wire logic [7:0] conv_count,
  input wire logic nvm_ok,
  output logic [5:0] nvm_addr,
  input wire logic [7:0] nvm_data,
  output logic [7:0] pins
);
  typedef struct packed {
    logic [2:0] scl_s, sda_s;
    logic scl_q, sda_q;
    tsm_slave_t sl;
    logic [7:0] sh;
    logic [3:0] bc;
    logic rw, first, nak, ack_drv, sda_oe_n;
    logic [5:0] ptr;
    logic [NREG-1:0][7:0] regs;
    tsm_scan_t sc;
    tsm_mode_t mode;
    logic [2:0] idx;
    logic conv_req, cbusy;
    logic [6:0] boot_i;
    logic [7:0] touch_w, touch, per_cnt, idle_cnt;
    logic [31:0] unit_cnt, fade_cnt, buzz_cnt, tone_cnt;
    logic irq_n, tone;
    logic [7:0] fade_on, level_coded_output_a, level_coded_output_b, pwm_cnt, pins;
    logic [7:0][7:0] lvl, width;
  } tsm_dev_t;

  tsm_dev_t s, n;
  logic scl_ok, sda_ok, rise, fall, start, stop;
  logic [1:0] eff;
  logic [8:0] thr_hi, cnt_lo;
  logic [7:0] chg, tgt, stp, w;

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = s.sda_oe_n;
  assign link.dev_irq_o = 1'b0;
  assign link.dev_irq_oe_n = s.irq_n;
  assign conv_req = s.conv_req;
  assign conv_idx = s.idx;
  assign nvm_addr = s.boot_i[5:0];
  assign pins = s.pins;

  always_comb begin
    n = s;
    n.conv_req = 1'b0;
    n.scl_s = {s.scl_s[1:0], link.scl};
    n.sda_s = {s.sda_s[1:0], link.sda};
    scl_ok = s.scl_s[2] == s.scl_s[1];
    sda_ok = s.sda_s[2] == s.sda_s[1];
    if (scl_ok) n.scl_q = s.scl_s[1];
    if (sda_ok) n.sda_q = s.sda_s[1];
    rise = scl_ok & s.scl_s[1] & ~s.scl_q;
    fall = scl_ok & ~s.scl_s[1] & s.scl_q;
    start = sda_ok & ~s.sda_s[1] & s.sda_q & s.scl_q;
    stop = sda_ok & s.sda_s[1] & ~s.sda_q & s.scl_q;
    // Two-wire slave with an auto-incrementing register pointer.
    if (start) begin
      n.sl = SL_ADDR;
      n.bc = 4'h0;
      n.ack_drv = 1'b0;
    end else if (stop) begin
      n.sl = SL_IDLE;
      n.ack_drv = 1'b0;
    end else begin
      case (s.sl)
        SL_ADDR, SL_WR: begin
          if (rise) begin
            n.sh = {s.sh[6:0], s.sda_q};
            n.bc = s.bc + 4'h1;
          end
          if (fall && s.bc == 4'h8) begin
            n.bc = 4'h0;
            if (s.sl == SL_ADDR) begin
              if (s.sh[7:1] == DEV_ADDR) begin
                n.ack_drv = 1'b1;
                n.rw = s.sh[0];
                n.first = 1'b1;
                n.sl = SL_ACKA;
              end else begin
                n.sl = SL_IDLE;
              end
            end else begin
              n.ack_drv = 1'b1;
              n.first = 1'b0;
              n.sl = SL_ACKW;
              if (s.first) begin
                n.ptr = s.sh[5:0];
              end else begin
                if (s.ptr != A_STAT && s.ptr != A_TOUCH)
                  n.regs[s.ptr] = s.sh;
                n.ptr = s.ptr + 6'h1;
              end
            end
          end
        end
        SL_ACKA, SL_ACKR: begin
          if (rise) n.nak = s.sda_q;
          if (fall) begin
            n.ack_drv = 1'b0;
            n.sl = SL_WR;
            if (s.sl == SL_ACKR && s.nak) begin
              n.sl = SL_IDLE;
            end else if (s.sl == SL_ACKR || s.rw) begin
              n.sh = s.regs[s.ptr];
              n.ptr = s.ptr + 6'h1;
              n.sl = SL_RD;
              if (s.ptr == A_STAT) begin
                n.regs[A_STAT] = 8'h00;
                n.irq_n = 1'b1;
              end
            end
          end
        end
        SL_ACKW: begin
          if (fall) begin
            n.ack_drv = 1'b0;
            n.sl = SL_WR;
          end
        end
        SL_RD: begin
          if (rise) n.bc = s.bc + 4'h1;
          if (fall) begin
            if (s.bc == 4'h8) begin
              n.bc = 4'h0;
              n.sl = SL_ACKR;
            end else begin
              n.sh = {s.sh[6:0], 1'b1};
            end
          end
        end
        default: n.sl = SL_IDLE;
      endcase
    end
    n.sda_oe_n = ~(n.ack_drv | (n.sl == SL_RD && !n.sh[7]));
    case (s.regs[A_MODE])
      MC_ACTIVE: eff = 2'd0;
      MC_DOZE: eff = 2'd1;
      MC_SLEEP: eff = 2'd2;
      default: eff = {1'b0, s.mode == MODE_DOZE};
    endcase
    thr_hi = {1'b0, s.regs[A_THR]} + {1'b0, s.regs[A_HYS]};
    cnt_lo = {1'b0, conv_count} + {1'b0, s.regs[A_HYS]};
    chg = s.touch_w ^ s.touch;
    // The period timer runs from the start of sensing, so the scan period
    // is measured start to start and does not grow with sensing time.
    if (s.sc == SC_SENSE || s.sc == SC_PROC || s.sc == SC_WAIT) begin
      n.unit_cnt = s.unit_cnt - 32'h1;
      if (s.unit_cnt == 32'h0) begin
        n.unit_cnt = UNIT_CYCLES[31:0] - 32'h1;
        if (s.per_cnt != 8'h0) n.per_cnt = s.per_cnt - 8'h1;
      end
    end
    // Scan sequencer.
    case (s.sc)
      SC_BOOT: begin
        n.boot_i = s.boot_i + 7'h1;
        if (s.boot_i != 7'h0 && s.boot_i[5:0] - 6'h1 > A_TOUCH)
          n.regs[s.boot_i[5:0] - 6'h1] = nvm_data;
        if (!nvm_ok || s.boot_i == 7'h40) begin
          n.boot_i = 7'h0;
          n.unit_cnt = UNIT_CYCLES[31:0] - 32'h1;
          n.per_cnt = s.regs[A_PER_ACT];
          n.sc = SC_SENSE;
        end
      end
      SC_SENSE: begin
        if (s.regs[A_SENSE_EN][s.idx] && !s.cbusy) begin
          n.conv_req = 1'b1;
          n.cbusy = 1'b1;
        end
        if (!s.regs[A_SENSE_EN][s.idx] || (s.cbusy && conv_done)) begin
          n.cbusy = 1'b0;
          if (!s.regs[A_SENSE_EN][s.idx]) n.touch_w[s.idx] = 1'b0;
          else if ({1'b0, conv_count} > thr_hi) n.touch_w[s.idx] = 1'b1;
          else if (cnt_lo < {1'b0, s.regs[A_THR]})
            n.touch_w[s.idx] = 1'b0;
          n.idx = s.idx + 3'h1;
          if (s.idx == 3'h7) n.sc = SC_PROC;
        end
      end
      SC_PROC: begin
        n.touch = s.touch_w;
        n.regs[A_TOUCH] = s.touch_w;
        n.regs[A_STAT] = n.regs[A_STAT] | chg;
        if (chg != 8'h00) n.irq_n = 1'b0;
        if (s.touch_w != 8'h00) begin
          n.idle_cnt = 8'h00;
          if (s.mode == MODE_DOZE && (chg & s.touch_w) != 8'h00)
            n.mode = MODE_ACTIVE;
        end else begin
          if (s.idle_cnt != 8'hff) n.idle_cnt = s.idle_cnt + 8'h1;
          if (s.regs[A_PASSIVE] != 8'h00 && n.idle_cnt >= s.regs[A_PASSIVE])
            n.mode = MODE_DOZE;
        end
        if ((chg & s.touch_w) != 8'h00 && s.regs[A_BUZZ_EN][0]) begin
          n.buzz_cnt = BUZZ_CYCLES[31:0];
          n.tone_cnt = 32'h0;
        end
        n.fade_on = s.regs[A_AUTOLIGHT][0] ? s.touch_w
          : s.regs[A_FADE_ON];
        n.level_coded_output_a = s.regs[A_AOI_IDLE];
        n.level_coded_output_b = s.regs[A_AOI_IDLE];
        for (int i = 7; i >= 0; i--) begin
          n.width[i] = s.regs[A_WIDTH + 6'(i)];
          if (s.touch_w[i]) begin
            if (s.regs[A_AOI_MAP][i]) n.level_coded_output_b = s.regs[A_AOI_LVL + 6'(i)];
            else n.level_coded_output_a = s.regs[A_AOI_LVL + 6'(i)];
          end
        end
        n.sc = eff == 2'd2 ? SC_SLEEP : SC_WAIT;
      end
      SC_WAIT: begin
        if (s.unit_cnt == 32'h0 && s.per_cnt <= 8'h1) begin
          n.sc = SC_SENSE;
          n.unit_cnt = UNIT_CYCLES[31:0] - 32'h1;
          n.per_cnt = eff == 2'd1 ? s.regs[A_PER_DOZE]
            : s.regs[A_PER_ACT];
        end
        if (eff == 2'd2) n.sc = SC_SLEEP;
      end
      SC_SLEEP: begin
        if (start) begin
          if (s.regs[A_MODE] == MC_SLEEP) n.regs[A_MODE] = MC_AUTO;
          n.mode = MODE_ACTIVE;
          n.unit_cnt = UNIT_CYCLES[31:0] - 32'h1;
          n.per_cnt = s.regs[A_PER_ACT];
          n.sc = SC_SENSE;
        end
      end
      default: n.sc = SC_SENSE;
    endcase
    // Fading, buzzer tone and the eight PWM generators.
    n.pwm_cnt = s.pwm_cnt + 8'h1;
    n.fade_cnt = s.fade_cnt - 32'h1;
    if (s.buzz_cnt != 32'h0) begin
      n.buzz_cnt = s.buzz_cnt - 32'h1;
      n.tone_cnt = s.tone_cnt - 32'h1;
      if (s.tone_cnt == 32'h0) begin
        n.tone_cnt = TONE_CYCLES[31:0] - 32'h1;
        n.tone = ~s.tone;
      end
    end
    for (int i = 0; i < 8; i++) begin
      tgt = s.fade_on[i] ? s.regs[A_FADE_MAX] : s.regs[A_FADE_MIN];
      stp = s.regs[A_FADE_CFG][FADE_LOG_BIT] ? (s.lvl[i] >> 3) + 8'h1
        : 8'h1;
      if (s.fade_cnt == 32'h0) begin
        if (s.lvl[i] < tgt)
          n.lvl[i] = (tgt - s.lvl[i] < stp) ? tgt : s.lvl[i] + stp;
        else if (s.lvl[i] > tgt)
          n.lvl[i] = (s.lvl[i] - tgt < stp) ? tgt : s.lvl[i] - stp;
      end
      w = s.regs[A_DIRECT][i] ? s.width[i] : s.lvl[i];
      n.pins[i] = s.pwm_cnt < w;
    end
    if (s.fade_cnt == 32'h0)
      n.fade_cnt = FADE_CYCLES[31:0]
        * {28'h0, s.regs[A_FADE_CFG][3:0] + 4'h1} - 32'h1;
    if (s.regs[A_SPECIAL][PIN_LEVEL_CODED_OUTPUT_A]) n.pins[PIN_LEVEL_CODED_OUTPUT_A] = s.pwm_cnt < s.level_coded_output_a;
    if (s.regs[A_SPECIAL][PIN_LEVEL_CODED_OUTPUT_B])
      n.pins[PIN_LEVEL_CODED_OUTPUT_B] = s.pwm_cnt < s.level_coded_output_b;
    if (s.regs[A_SPECIAL][PIN_BUZZ])
      n.pins[PIN_BUZZ] = (s.buzz_cnt != 32'h0) & s.tone;
    if (s.sc == SC_SLEEP) n.pins = 8'h00;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.scl_s <= 3'h7;
      s.sda_s <= 3'h7;
      s.scl_q <= 1'b1;
      s.sda_q <= 1'b1;
      s.sda_oe_n <= 1'b1;
      s.irq_n <= 1'b1;
      s.sc <= SC_BOOT;
      s.regs[A_PER_ACT] <= R_PER_ACT;
      s.regs[A_PER_DOZE] <= R_PER_DOZE;
      s.regs[A_PASSIVE] <= R_PASSIVE;
      s.regs[A_AUTOLIGHT] <= R_AUTOLIGHT;
      s.regs[A_FADE_CFG] <= R_FADE_CFG;
      s.regs[A_FADE_MAX] <= R_FADE_MAX;
      s.regs[A_THR] <= R_THR;
      s.regs[A_HYS] <= R_HYS;
      s.regs[A_SENSE_EN] <= R_SENSE_EN;
    end else begin
      s <= n;
    end
  end
endmodule

// ===== rtl/tsm_host.sv
// Host end: drives the two-wire link as master and offers a command port.
// Assumes a pull-up on every wire and a device that never stretches clock.
`timescale 1ns/1ps
module tsm_host import tsm_pkg::*; #(
  parameter int QUART = QUART_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  tsm_link_if.host link,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  typedef struct packed {
    logic [2:0] sda_s, irq_s;
    logic sda_q, irq_q;
    tsm_hst_t st;
    logic [1:0] q;
    logic [15:0] div;
    logic [3:0] bitn;
    logic [2:0] bidx;
    logic [7:0] sh, rx, reg_a, wd, rd_val, rdata;
    logic op_rd, busy, err, scl_oe_n, sda_oe_n;
  } tsm_host_t;

  tsm_host_t s, n;
  logic tick;

  function automatic logic [7:0] byte_of(input logic [2:0] b,
    input logic [7:0] ra, input logic [7:0] wv);
    case (b)
      3'd0: byte_of = {DEV_ADDR, 1'b0};
      3'd1: byte_of = ra;
      3'd2: byte_of = wv;
      3'd3: byte_of = {DEV_ADDR, 1'b1};
      default: byte_of = 8'hff;
    endcase
  endfunction

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe_n = s.scl_oe_n;
  assign link.host_sda_oe_n = s.sda_oe_n;
  assign rdata = s.rdata;

  always_comb begin
    n = s;
    n.sda_s = {s.sda_s[1:0], link.sda};
    n.irq_s = {s.irq_s[1:0], link.irq_n};
    if (s.sda_s[2] == s.sda_s[1]) n.sda_q = s.sda_s[1];
    if (s.irq_s[2] == s.irq_s[1]) n.irq_q = s.irq_s[1];
    n.rdata = 8'h00;
    if (rd) begin
      case (addr)
        H_REG: n.rdata = s.reg_a;
        H_WDATA: n.rdata = s.wd;
        H_RDATA: n.rdata = s.rd_val;
        H_STAT: n.rdata = {5'h0, ~s.irq_q, s.err, s.busy};
        default: n.rdata = 8'h00;
      endcase
    end
    if (wr && !s.busy) begin
      case (addr)
        H_CMD: begin
          if (wdata[0]) begin
            n.busy = 1'b1;
            n.err = 1'b0;
            n.op_rd = wdata[1];
            n.bidx = 3'd0;
            n.st = HS_START;
            n.q = 2'd0;
            n.div = QUART[15:0] - 16'h1;
          end
        end
        H_REG: n.reg_a = wdata;
        H_WDATA: n.wd = wdata;
        default: n.wd = s.wd;
      endcase
    end
    tick = s.busy && s.div == 16'h0;
    if (s.busy) n.div = tick ? QUART[15:0] - 16'h1 : s.div - 16'h1;
    if (tick) begin
      n.q = s.q + 2'd1;
      case (s.st)
        HS_START: begin
          case (s.q)
            2'd0: begin
              n.scl_oe_n = 1'b1;
              n.sda_oe_n = 1'b1;
            end
            2'd1: n.sda_oe_n = 1'b0;
            2'd2: n.scl_oe_n = 1'b0;
            default: begin
              n.st = HS_BIT;
              n.bitn = 4'h0;
              n.sh = byte_of(s.bidx, s.reg_a, s.wd);
            end
          endcase
        end
        HS_BIT: begin
          case (s.q)
            2'd0: n.sda_oe_n = s.bitn == 4'h8 ? 1'b1 : s.sh[7];
            2'd1: n.scl_oe_n = 1'b1;
            2'd2: begin
              if (s.bitn != 4'h8) n.rx = {s.rx[6:0], s.sda_q};
              else if (s.bidx != 3'd4) n.err = s.err | s.sda_q;
            end
            default: begin
              n.scl_oe_n = 1'b0;
              n.bitn = s.bitn + 4'h1;
              n.sh = {s.sh[6:0], 1'b1};
              if (s.bitn == 4'h8) begin
                n.bitn = 4'h0;
                if (s.bidx == 3'd4) n.rd_val = s.rx;
                if (s.bidx == 3'd2 || s.bidx == 3'd4
                    || (s.bidx == 3'd1 && s.op_rd)) begin
                  n.st = HS_STOP;
                end else begin
                  n.bidx = s.bidx + 3'd1;
                  n.sh = byte_of(s.bidx + 3'd1, s.reg_a, s.wd);
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          case (s.q)
            2'd0: n.sda_oe_n = 1'b0;
            2'd1: n.scl_oe_n = 1'b1;
            2'd2: n.sda_oe_n = 1'b1;
            default: begin
              if (s.op_rd && s.bidx == 3'd1) begin
                n.bidx = 3'd3;
                n.st = HS_START;
              end else begin
                n.st = HS_IDLE;
                n.busy = 1'b0;
              end
            end
          endcase
        end
        default: n.st = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s <= '0;
      s.sda_s <= 3'h7;
      s.irq_s <= 3'h7;
      s.sda_q <= 1'b1;
      s.irq_q <= 1'b1;
      s.scl_oe_n <= 1'b1;
      s.sda_oe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule

// ===== tb/tsm_link_chk.sv
// Checker on the two-wire link joining the host and device ends.
// Assumes one core clock and a link quarter bit of 8 cycles.
`timescale 1ns/1ps
module tsm_link_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic irq_n,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic dev_irq_o,
  input wire logic dev_irq_oe_n
);
  logic [7:0] idle_r;
  // Counts clock cycles that the link clock has stood high in a row.
  always_ff @(posedge core_clk) begin
    if (rst || !scl) idle_r <= 8'h00;
    else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence irq_set;
    $fell(irq_n);
  endsequence
  sequence irq_held;
    !irq_n [*8];
  endsequence
  AST_OPEN_DRAIN: assert property (!dev_sda_o && !dev_irq_o)
    else $error("device drives a wire high");
  AST_RESET_FREE: assert property ($fell(rst) |-> dev_irq_oe_n
    && dev_sda_oe_n && host_scl_oe_n && host_sda_oe_n)
    else $error("a wire is held after reset");
  AST_IRQ_HOLD: assert property (irq_set |-> irq_held)
    else $error("interrupt dropped without a status read");
  AST_IRQ_FREE: assert property ($rose(irq_n) |-> idle_r < 8'h40)
    else $error("interrupt released while the link is idle");
  AST_SDA_EDGE: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("device moved data while clock high");
  AST_SDA_BIT: assert property ($fell(dev_sda_oe_n) |->
    !dev_sda_oe_n [*8])
    else $error("device data bit too short");
  AST_SDA_QUIET: assert property (idle_r == 8'hff |-> dev_sda_oe_n)
    else $error("device holds data on an idle link");
  AST_SCL_LOW: assert property ($fell(scl) |-> !scl [*8])
    else $error("link clock low phase too short");
  cover property (irq_set);
endmodule

// ===== tb/touch_scan_mode_controller_tb.sv
// Bench joining host and device ends; drives both user sides.
// Assumes shortened counts: one period unit is 200 core cycles.
`timescale 1ns/1ps
module touch_scan_mode_controller_tb import tsm_pkg::*;;
  localparam int UNIT = 200;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic conv_req, conv_done, nvm_ok, wr, rd, chk_d;
  logic [2:0] conv_idx, addr;
  logic [5:0] nvm_addr;
  logic [7:0] conv_count, nvm_data, pins, wdata, rdata, w;
  logic [7:0] cnt [8];
  logic [7:0] mem [64];
  logic [7:0] q [$];
  int failures, n_compared, cyc_n, t0, gap, nstart, h, n0;
  int last_idx = 7;
  tsm_link_if link();
  tsm_device #(.UNIT_CYCLES(UNIT), .BUZZ_CYCLES(400), .TONE_CYCLES(20),
    .FADE_CYCLES(10)) i_tsm_device (.core_clk(core_clk), .rst(rst),
    .link(link), .conv_req(conv_req), .conv_idx(conv_idx),
    .conv_done(conv_done), .conv_count(conv_count), .nvm_ok(nvm_ok),
    .nvm_addr(nvm_addr), .nvm_data(nvm_data), .pins(pins));
  tsm_host #(.QUART(8)) i_tsm_host (.core_clk(core_clk), .rst(rst),
    .link(link), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  tsm_link_chk i_tsm_link_chk (.core_clk(core_clk), .rst(rst),
    .scl(link.scl), .sda(link.sda), .irq_n(link.irq_n),
    .host_scl_oe_n(link.host_scl_oe_n),
    .host_sda_oe_n(link.host_sda_oe_n), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe_n(link.dev_sda_oe_n), .dev_irq_o(link.dev_irq_o),
    .dev_irq_oe_n(link.dev_irq_oe_n));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic port(input logic [2:0] a, input logic [7:0] d,
    input logic w_i, input logic r_i);
    addr <= a;
    wdata <= d;
    wr <= w_i;
    rd <= r_i;
    @(posedge core_clk);
  endtask
  task automatic xfer(input logic [5:0] ra, input logic [7:0] d,
    input logic [7:0] cmd);
    logic [7:0] s;
    int n;
    port(H_REG, {2'b00, ra}, 1'b1, 1'b0);
    port(H_WDATA, d, 1'b1, 1'b0);
    port(H_CMD, cmd, 1'b1, 1'b0);
    n = 0;
    do begin
      port(H_STAT, 8'h00, 1'b0, 1'b1);
      rd <= 1'b0;
      @(negedge core_clk) s = rdata;
      @(posedge core_clk);
      n++;
    end while (s[0] !== 1'b0 && n < 4000);
    if (n >= 4000) failures++;
  endtask
  task automatic wreg(input logic [5:0] ra, input logic [7:0] d);
    xfer(ra, d, 8'h01);
  endtask
  task automatic rreg(input logic [5:0] ra, input logic [7:0] e);
    xfer(ra, 8'h00, 8'h03);
    q.push_back(e);
    port(H_RDATA, 8'h00, 1'b0, 1'b1);
    rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_scans(input int k);
    int b, c;
    b = nstart;
    c = 0;
    while (nstart < b + k && c < 30000) begin
      @(posedge core_clk);
      c++;
    end
    if (c >= 30000) failures++;
  endtask
  task automatic per_chk(input int e);
    wait_scans(4);
    cmp("period", e, gap);
  endtask
  task automatic wait_irq;
    int c;
    c = 0;
    while (link.irq_n !== 1'b0 && c < 6000) begin
      @(posedge core_clk);
      c++;
    end
    cmp("irq_n", 0, link.irq_n);
  endtask
  task automatic pwm(input int p, output int n);
    n = 0;
    repeat (512) @(negedge core_clk) n += pins[p];
  endtask
  // Front end and boot memory answer one cycle after each request.
  always @(posedge core_clk) begin
    conv_done <= conv_req;
    conv_count <= cnt[conv_idx];
    nvm_data <= mem[nvm_addr];
    chk_d <= rd === 1'b1 && addr === H_RDATA;
  end
  always @(negedge core_clk) begin
    cyc_n++;
    if (chk_d) cmp("rdata", q.pop_front(), rdata);
    if (conv_req === 1'b1) begin
      if (conv_idx !== 3'h0) cmp("conv_idx", last_idx + 1, conv_idx);
      else begin
        gap = cyc_n - t0;
        t0 = cyc_n;
        nstart++;
      end
      last_idx = conv_idx;
    end
  end
  initial begin
    repeat (90000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
  initial begin
    {conv_done, wr, rd, addr, wdata, conv_count, nvm_data} = '0;
    nvm_ok = 1'b1;
    void'($urandom(46));
    for (int i = 0; i < 8; i++) cnt[i] = 8'($urandom_range(8'h70));
    for (int i = 0; i < 64; i++) mem[i] = 8'h00;
    mem[A_PER_ACT] = 8'h03;
    mem[A_PER_DOZE] = R_PER_DOZE;
    mem[A_AUTOLIGHT] = R_AUTOLIGHT;
    mem[A_FADE_CFG] = R_FADE_CFG;
    mem[A_FADE_MAX] = R_FADE_MAX;
    mem[A_THR] = R_THR;
    mem[A_HYS] = R_HYS;
    mem[A_SENSE_EN] = R_SENSE_EN;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    per_chk(3 * UNIT);
    wreg(A_PER_ACT, 8'h01);
    per_chk(UNIT);
    wreg(A_MODE, MC_SLEEP);
    repeat (400) @(posedge core_clk);
    n0 = nstart;
    repeat (1000) @(posedge core_clk);
    cmp("sleep", n0, nstart);
    rreg(A_MODE, MC_AUTO);
    per_chk(UNIT);
    wreg(A_PASSIVE, 8'h02);
    per_chk(13 * UNIT);
    cnt[3] = 8'h88;
    wait_scans(2);
    rreg(A_TOUCH, 8'h00);
    cnt[3] = 8'h89;
    wait_irq();
    rreg(A_STAT, 8'h08);
    cmp("irq_n", 1, link.irq_n);
    rreg(A_TOUCH, 8'h08);
    per_chk(UNIT);
    pwm(3, h);
    cmp("lit", 1, h > 0);
    wreg(A_DIRECT, 8'h01);
    repeat (2) begin
      w = 8'($urandom);
      wreg(A_WIDTH, w);
      wait_scans(2);
      pwm(0, h);
      cmp("pwm", 2 * w, h);
    end
    cnt[3] = 8'h78;
    wait_scans(2);
    rreg(A_TOUCH, 8'h08);
    cnt[3] = 8'h77;
    wait_scans(2);
    rreg(A_TOUCH, 8'h00);
    wreg(A_MODE, MC_DOZE);
    per_chk(13 * UNIT);
    wrap_up();
  end
endmodule
